// ### hdl/avf_defs.vh
`ifndef AVF_DEFS_VH
`define AVF_DEFS_VH

// Register index times four gives the byte address.
`define AVF_IDX_RVOL      8'h05
`define AVF_IDX_ANALOG    8'h06
`define AVF_IDX_RSVD7     8'h07
`define AVF_IDX_FAULT     8'h08
`define AVF_IDX_IRQ_STAT  8'h09
`define AVF_IDX_IRQ_MASK  8'h0a
`define AVF_IDX_CTRL      8'h0b

`define AVF_RVOL_RESET    8'hcf
`define AVF_RVOL_MAX      8'hff
`define AVF_RVOL_FLOOR    8'h07
`define AVF_ANALOG_RESET  8'h51
`define AVF_FAULT_RESET   2'h0
`define AVF_AGAIN_RSVD    2'h3

`define AVF_AN_MONO_BIT   7
`define AVF_AN_RATE_HI    6
`define AVF_AN_RATE_LO    4
`define AVF_AN_GAIN_HI    3
`define AVF_AN_GAIN_LO    2
`define AVF_AN_SRC_BIT    1
`define AVF_AN_RSVD_BIT   0

`define AVF_FT_TRIP_HI    5
`define AVF_FT_TRIP_LO    4
`define AVF_FT_CLK_BIT    3
`define AVF_FT_OC_BIT     2
`define AVF_FT_DC_BIT     1
`define AVF_FT_OT_BIT     0

`define AVF_CTRL_DS_BIT   0

`endif

// ### hdl/avf_sync2.v
`default_nettype none

// ==========================================================
// Two flip-flop synchroniser for a level from another domain.
module avf_sync2 (
	input  wire clock,
	input  wire rst_b,
	input  wire d,
	output reg  q
);

	reg meta_q;

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

`default_nettype wire

// ### hdl/avf_fault_flag.v
`default_nettype none

// ==========================================================
// One fault flag: latching or following its synchronised source.
module avf_fault_flag #(
	parameter LATCH = 1
) (
	input  wire clock,
	input  wire rst_b,
	input  wire raw,
	input  wire release_pulse,
	output reg  flag_q
);

	wire sync_w;

	avf_sync2 u_sync (
		.clock (clock),
		.rst_b (rst_b),
		.d     (raw),
		.q     (sync_w)
	);

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			flag_q <= 1'b0;
		end else if (LATCH == 0) begin
			flag_q <= sync_w;
		end else if (sync_w) begin
			flag_q <= 1'b1;
		end else if (release_pulse) begin
			flag_q <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ### hdl/avf_regs.v
// Operation
// - All-ones volume code gives +24 dB
// - Each code step lowers gain 0.5 dB
// - Volume resets to 0 dB code
// - Code seven -100 dB, below mutes
// - Bit 7 selects stereo or mono bridge
// - Bits 6:4 set switching rate multiple
// - Double speed halves switching frequency
// - Bits 3:2 select analog gain
// - Bit 1 picks mono source slot
// - Bit 0 reserved, resets to one
// - Fault trip field writable, flags read-only
// - Trip code scales nominal level down
// - Clock error flag follows, no latch
// - Other flags latch until shutdown toggled
`include "avf_defs.vh"
`default_nettype none

module avf_regs (
	input  wire        clock,
	input  wire        rst_b,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        clock_fault_raw,
	input  wire        overcurrent_raw,
	input  wire        dc_fault_raw,
	input  wire        overtemp_raw,
	input  wire        speaker_shutdown_pin,
	output reg  [7:0]  right_gain_code,
	output reg         right_mute,
	output reg  [8:0]  right_atten_half_db,
	output reg         parallel_bridged_mono,
	output reg  [4:0]  switch_mult,
	output reg         switch_half,
	output reg  [1:0]  analog_gain_sel,
	output reg         mono_source_select,
	output reg  [1:0]  overcurrent_trip_level,
	output reg  [2:0]  trip_quarters,
	output reg         irq
);

	// ==========================================================
	// Register state.
	reg  [7:0] rvol_q;
	reg  [7:0] analog_q;
	reg  [1:0] trip_q;
	reg  [3:0] istat_q;
	reg  [3:0] imask_q;
	reg        ds_q;
	reg        sd_prev_q;
	wire       sd_w;
	wire [3:0] flags_w;
	wire       sd_release_w;
	wire       sd_toggle_w;

	avf_sync2 u_sd_sync (
		.clock (clock),
		.rst_b (rst_b),
		.d     (speaker_shutdown_pin),
		.q     (sd_w)
	);

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sd_prev_q <= 1'b0;
		end else begin
			sd_prev_q <= sd_w;
		end
	end

	// Low-to-high on the shutdown pin completes the toggle.
	assign sd_toggle_w  = sd_w & ~sd_prev_q;
	assign sd_release_w = sd_toggle_w;

	// ==========================================================
	// Fault flags.
	avf_fault_flag #(.LATCH(0)) u_clk_flag (
		.clock         (clock),
		.rst_b         (rst_b),
		.raw           (clock_fault_raw),
		.release_pulse (1'b0),
		.flag_q        (flags_w[`AVF_FT_CLK_BIT])
	);

	avf_fault_flag #(.LATCH(1)) u_oc_flag (
		.clock         (clock),
		.rst_b         (rst_b),
		.raw           (overcurrent_raw),
		.release_pulse (sd_release_w),
		.flag_q        (flags_w[`AVF_FT_OC_BIT])
	);

	avf_fault_flag #(.LATCH(1)) u_dc_flag (
		.clock         (clock),
		.rst_b         (rst_b),
		.raw           (dc_fault_raw),
		.release_pulse (sd_release_w),
		.flag_q        (flags_w[`AVF_FT_DC_BIT])
	);

	avf_fault_flag #(.LATCH(1)) u_ot_flag (
		.clock         (clock),
		.rst_b         (rst_b),
		.raw           (overtemp_raw),
		.release_pulse (sd_release_w),
		.flag_q        (flags_w[`AVF_FT_OT_BIT])
	);

	// ==========================================================
	// APB decode.
	wire       access_w = psel & penable & pready;
	wire       wr_w     = access_w & pwrite;
	wire [9:0] idx_w    = paddr[11:2];
	wire       hit_w    = (idx_w == {2'h0, `AVF_IDX_RVOL})
		| (idx_w == {2'h0, `AVF_IDX_ANALOG})
		| (idx_w == {2'h0, `AVF_IDX_RSVD7})
		| (idx_w == {2'h0, `AVF_IDX_FAULT})
		| (idx_w == {2'h0, `AVF_IDX_IRQ_STAT})
		| (idx_w == {2'h0, `AVF_IDX_IRQ_MASK})
		| (idx_w == {2'h0, `AVF_IDX_CTRL});
	wire       rsvd_w   = (idx_w == {2'h0, `AVF_IDX_RSVD7});
	wire       misal_w  = (paddr[1:0] != 2'h0);
	reg  [7:0] rd_byte;

	always @* begin
		rd_byte = 8'h00;
		case (idx_w[7:0])
			`AVF_IDX_RVOL:     rd_byte = rvol_q;
			`AVF_IDX_ANALOG:   rd_byte = analog_q;
			`AVF_IDX_FAULT:    rd_byte = {2'h0, trip_q, flags_w};
			`AVF_IDX_IRQ_STAT: rd_byte = {4'h0, istat_q};
			`AVF_IDX_IRQ_MASK: rd_byte = {4'h0, imask_q};
			`AVF_IDX_CTRL:     rd_byte = {7'h00, ds_q};
			default:           rd_byte = 8'h00;
		endcase
		if (idx_w[9:8] != 2'h0) begin
			rd_byte = 8'h00;
		end
	end

	// Every access completes with no wait state: pready is high in the first access cycle.
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & (~hit_w | rsvd_w | misal_w);
			if (psel & ~penable & ~pwrite) begin
				prdata <= {24'h00_0000, rd_byte};
			end else if (access_w) begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	wire wr_ok_w = wr_w & ~pslverr;

	// ==========================================================
	// Writable registers.
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rvol_q   <= `AVF_RVOL_RESET;
			analog_q <= `AVF_ANALOG_RESET;
			trip_q   <= `AVF_FAULT_RESET;
			imask_q  <= 4'h0;
			ds_q     <= 1'b0;
		end else if (wr_ok_w) begin
			case (idx_w[7:0])
				`AVF_IDX_RVOL:     rvol_q <= pwdata[7:0];
				`AVF_IDX_ANALOG:   analog_q <= pwdata[7:0];
				`AVF_IDX_FAULT:
					trip_q <= pwdata[`AVF_FT_TRIP_HI:`AVF_FT_TRIP_LO];
				`AVF_IDX_IRQ_MASK: imask_q <= pwdata[3:0];
				`AVF_IDX_CTRL:     ds_q <= pwdata[`AVF_CTRL_DS_BIT];
				default:           rvol_q <= rvol_q;
			endcase
		end
	end

	// Sticky status: a new event wins over a write-one clear.
	wire [3:0] clr_w = (wr_ok_w && idx_w[7:0] == `AVF_IDX_IRQ_STAT)
		? pwdata[3:0] : 4'h0;

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			istat_q <= 4'h0;
		end else begin
			istat_q <= (istat_q & ~clr_w) | flags_w;
		end
	end

	// ==========================================================
	// Decoded controls for the analog and audio paths.
	reg [4:0] mult_d;
	reg [2:0] quarters_d;
	wire [8:0] atten_d = {1'b0, `AVF_RVOL_MAX} - {1'b0, rvol_q};

	always @* begin
		case (analog_q[`AVF_AN_RATE_HI:`AVF_AN_RATE_LO])
			3'h0:    mult_d = 5'h06;
			3'h1:    mult_d = 5'h08;
			3'h2:    mult_d = 5'h0a;
			3'h3:    mult_d = 5'h0c;
			3'h4:    mult_d = 5'h0e;
			3'h5:    mult_d = 5'h10;
			3'h6:    mult_d = 5'h14;
			default: mult_d = 5'h18;
		endcase
		case (trip_q)
			2'h0:    quarters_d = 3'h4;
			2'h1:    quarters_d = 3'h3;
			2'h2:    quarters_d = 3'h2;
			default: quarters_d = 3'h1;
		endcase
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			right_gain_code        <= `AVF_RVOL_RESET;
			right_mute             <= 1'b0;
			right_atten_half_db    <= 9'h030;
			parallel_bridged_mono  <= 1'b0;
			switch_mult            <= 5'h10;
			switch_half            <= 1'b0;
			analog_gain_sel        <= 2'h0;
			mono_source_select     <= 1'b0;
			overcurrent_trip_level <= 2'h0;
			trip_quarters          <= 3'h4;
			irq                    <= 1'b0;
		end else begin
			right_gain_code        <= rvol_q;
			right_mute             <= (rvol_q < `AVF_RVOL_FLOOR);
			right_atten_half_db    <= atten_d;
			parallel_bridged_mono  <= analog_q[`AVF_AN_MONO_BIT];
			switch_mult            <= mult_d;
			switch_half            <= ds_q;
			// Reserved code 11 is passed as written.
			analog_gain_sel        <= analog_q[`AVF_AN_GAIN_HI:`AVF_AN_GAIN_LO];
			mono_source_select     <= analog_q[`AVF_AN_SRC_BIT];
			overcurrent_trip_level <= trip_q;
			trip_quarters          <= quarters_d;
			irq                    <= |(istat_q & imask_q);
		end
	end

endmodule

`default_nettype wire

// ### tb/avf_regs_props.sv
`default_nettype none
// ====
// Register block port checks.
module avf_regs_props (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  right_gain_code,
	input wire logic        right_mute,
	input wire logic [8:0]  right_atten_half_db,
	input wire logic [4:0]  switch_mult,
	input wire logic [1:0]  overcurrent_trip_level,
	input wire logic [2:0]  trip_quarters
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence s_setup; psel && !penable; endsequence
	sequence s_wr(a); psel && penable && pready && pwrite && paddr == a;
	endsequence
	property p_ans; s_setup |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("late ready");
	property p_rsvd; pready && paddr == 12'h01c |-> pslverr; endproperty
	a_rsvd: assert property (p_rsvd) else $error("no refusal");
	property p_vol;
		s_wr(12'h014) |-> ##2 right_gain_code == $past(pwdata[7:0], 2);
	endproperty
	a_vol: assert property (p_vol) else $error("volume lost");
	property p_trip;
		s_wr(12'h020) |-> ##2 overcurrent_trip_level == $past(pwdata[5:4], 2);
	endproperty
	a_trip: assert property (p_trip) else $error("trip lost");
	property p_mute; right_mute == (right_gain_code < 8'h07); endproperty
	a_mute: assert property (p_mute) else $error("bad mute");
	property p_att; right_atten_half_db == 9'h0ff - right_gain_code;
	endproperty
	a_att: assert property (p_att) else $error("bad atten");
	property p_qtr; trip_quarters == 3'h4 - overcurrent_trip_level;
	endproperty
	a_qtr: assert property (p_qtr) else $error("bad quarters");
	property p_mult; switch_mult inside {5'h06, 5'h08, 5'h0a, 5'h0c,
		5'h0e, 5'h10, 5'h14, 5'h18}; endproperty
	a_mult: assert property (p_mult) else $error("bad rate");
endmodule
bind avf_regs avf_regs_props avf_regs_props_inst (.*);
`default_nettype wire

// ### tb/test_avf_regs.sv
`default_nettype none
// ====
// Register block bench.
module test_avf_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic        sd_pin = 1, er, pready, pslverr, mute, mono, half, src, irq;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd, prdata;
	logic [3:0]  raw = 0;
	logic [7:0]  gcode, w;
	logic [8:0]  atten;
	logic [4:0]  mult;
	logic [1:0]  gsel, trip;
	logic [2:0]  quart;
	int          n_mismatch = 0, checks = 0, i;
	logic [7:0]  vt [6] = '{8'hff, 8'hfe, 8'hcf, 8'h07, 8'h06, 8'h00};
	logic [4:0]  mt [8] = '{5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10,
		5'h14, 5'h18};
	avf_regs avf_regs_inst (.clock(clock), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.clock_fault_raw(raw[3]), .overcurrent_raw(raw[2]),
		.dc_fault_raw(raw[1]), .overtemp_raw(raw[0]),
		.speaker_shutdown_pin(sd_pin), .right_gain_code(gcode),
		.right_mute(mute), .right_atten_half_db(atten),
		.parallel_bridged_mono(mono), .switch_mult(mult),
		.switch_half(half), .analog_gain_sel(gsel),
		.mono_source_select(src), .overcurrent_trip_level(trip),
		.trip_quarters(quart), .irq(irq));
	initial forever #10 clock = ~clock;
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task apb(input logic wt, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= wt;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do @(posedge clock); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
		cyc(2);
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(1'h0, a, 32'h0);
		chk("prdata", e, rd);
		chk("pslverr", ee, er);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		cyc(4);
		rst_b <= 1'h1;
		rc(12'h014, 32'hcf, 1'h0);
		rc(12'h018, 32'h51, 1'h0);
		chk("quarters", 3'h4, quart);
		$display("test reset done");
		for (i = 0; i < 6; i++) begin
			wr(12'h014, {24'h0, vt[i]});
			chk("mute", vt[i] < 8'h07, mute);
			chk("gcode", vt[i], gcode);
			chk("atten", 9'h0ff - vt[i], atten);
			rc(12'h014, {24'h0, vt[i]}, 1'h0);
		end
		for (i = 0; i < 8; i++) begin
			w = {i[0], i[2:0], i[1:0] == 2'h3 ? 2'h0 : i[1:0], i[1], 1'h1};
			wr(12'h018, {24'h0, w});
			chk("mult", mt[i], mult);
			chk("gain", w[3:2], gsel);
			chk("mono", w[7], mono);
			chk("src", w[1], src);
			rc(12'h018, {24'h0, w}, 1'h0);
		end
		wr(12'h02c, 32'h1);
		chk("half", 1'h1, half);
		rc(12'h01c, 32'h0, 1'h1);
		rc(12'h040, 32'h0, 1'h1);
		$display("test control done");
		raw <= 4'h1;
		cyc(8);
		chk("irq", 1'h0, irq);
		wr(12'h028, 32'hf);
		chk("irq", 1'h1, irq);
		for (i = 0; i < 4; i++) begin
			raw <= 4'h1 << i;
			cyc(8);
			rc(12'h024, 32'h1 << i, 1'h0);
			raw <= 4'h0;
			cyc(8);
			rc(12'h020, i == 3 ? 32'h0 : 32'h1 << i, 1'h0);
			sd_pin <= 1'h0;
			cyc(4);
			sd_pin <= 1'h1;
			cyc(8);
			rc(12'h020, 32'h0, 1'h0);
			wr(12'h024, 32'hf);
			chk("irq", 1'h0, irq);
		end
		for (i = 0; i < 4; i++) begin
			wr(12'h020, {26'h0, i[1:0], 4'hf});
			chk("trip", i[1:0], trip);
			chk("quarters", 4 - i, quart);
			rc(12'h020, {26'h0, i[1:0], 4'h0}, 1'h0);
		end
		$display("test fault done");
		print_verdict;
	end
	initial begin
		#200000;
		n_mismatch++;
		print_verdict;
	end
endmodule
`default_nettype wire
